//--- updown_timer_pkg.sv
package updown_timer_pkg;

   // Register addresses on the plain register port
   localparam logic [3:0] ADDR_CONTROL  = 4'h0;
   localparam logic [3:0] ADDR_MODE     = 4'h1;
   localparam logic [3:0] ADDR_CNT_LO   = 4'h2;
   localparam logic [3:0] ADDR_CNT_HI   = 4'h3;
   localparam logic [3:0] ADDR_CAP_LO   = 4'h4;
   localparam logic [3:0] ADDR_CAP_HI   = 4'h5;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;

   // Control register bit positions
   localparam int CTL_CAP_RELOAD = 0;
   localparam int CTL_CLK_SRC    = 1;
   localparam int CTL_RUN        = 2;
   localparam int CTL_EXT_TRIG   = 3;
   localparam int CTL_TX_RATE    = 4;
   localparam int CTL_RX_RATE    = 5;
   localparam int CTL_EXT_FLAG   = 6;
   localparam int CTL_OVF_FLAG   = 7;

   // Mode register bit positions
   localparam int MOD_UPDOWN     = 0;
   localparam int MOD_FAST_PRE   = 1;
   localparam int MOD_CAP_CLEAR  = 3;

   // Interrupt status and mask bit positions
   localparam int IRQ_OVF        = 0;
   localparam int IRQ_EXT        = 1;

   // Reset values and count constants
   localparam logic [7:0]  CONTROL_RST = 8'h00;
   localparam logic [7:0]  MODE_RST    = 8'h00;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;
   localparam logic [15:0] COUNT_ZERO  = 16'h0000;
   localparam int          PRESCALE_SLOW = 12;
   localparam int          PRESCALE_FAST = 4;

   typedef enum {
      MODE_CAPTURE,
      MODE_RELOAD_UP,
      MODE_RELOAD_UPDOWN,
      MODE_RATE_GEN
   } timer_mode_type;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_type;

endpackage

//--- updown_capture_reload_timer.sv
`timescale 1ns/100ps
module updown_capture_reload_timer (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic       i_ext_count_pin,
   input  wire logic       i_trigger_direction_pin,
   output logic      [7:0] o_rdata,
   output logic            o_irq,
   output logic            o_rate_overflow
);

   updown_timer_pkg::reg_req_type req;
   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // Two-flop synchronisers for both pins, then one history flop
   logic [1:0] cnt_sync_reg;
   logic [1:0] trg_sync_reg;
   logic       cnt_last_reg;
   logic       trg_last_reg;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_sync_reg <= 2'h3;
         trg_sync_reg <= 2'h3;
         cnt_last_reg <= 1'b1;
         trg_last_reg <= 1'b1;
      end else begin
         cnt_sync_reg <= {cnt_sync_reg[0], i_ext_count_pin};
         trg_sync_reg <= {trg_sync_reg[0], i_trigger_direction_pin};
         cnt_last_reg <= cnt_sync_reg[1];
         trg_last_reg <= trg_sync_reg[1];
      end
   end

   logic cnt_fall;
   logic trg_fall;
   logic trg_level;
   assign cnt_fall  = cnt_last_reg & ~cnt_sync_reg[1];
   assign trg_fall  = trg_last_reg & ~trg_sync_reg[1];
   assign trg_level = trg_sync_reg[1];

   // Registers
   logic [7:0]  timer_control_reg;
   logic [7:0]  timer_control_next;
   logic [7:0]  timer_mode_reg;
   logic [7:0]  timer_mode_next;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [15:0] capture_reg;
   logic [15:0] capture_next;
   logic [1:0]  irq_stat_reg;
   logic [1:0]  irq_stat_next;
   logic [1:0]  irq_mask_reg;
   logic [1:0]  irq_mask_next;
   logic [3:0]  pre_reg;
   logic [3:0]  pre_next;
   logic [7:0]  rdata_next;
   logic        rate_ovf_next;

   logic run;
   logic clk_src;
   logic cap_sel;
   logic ext_en;
   logic updown;
   logic cap_clr;
   assign run     = timer_control_reg[updown_timer_pkg::CTL_RUN];
   assign clk_src = timer_control_reg[updown_timer_pkg::CTL_CLK_SRC];
   assign cap_sel = timer_control_reg[updown_timer_pkg::CTL_CAP_RELOAD];
   assign ext_en  = timer_control_reg[updown_timer_pkg::CTL_EXT_TRIG];
   assign updown  = timer_mode_reg[updown_timer_pkg::MOD_UPDOWN];
   assign cap_clr = timer_mode_reg[updown_timer_pkg::MOD_CAP_CLEAR];

   // Mode decode; rate select wins over capture select
   updown_timer_pkg::timer_mode_type mode;
   always_comb begin
      if (timer_control_reg[updown_timer_pkg::CTL_TX_RATE] |
          timer_control_reg[updown_timer_pkg::CTL_RX_RATE]) begin
         mode = updown_timer_pkg::MODE_RATE_GEN;
      end else if (cap_sel) begin
         mode = updown_timer_pkg::MODE_CAPTURE;
      end else if (updown) begin
         mode = updown_timer_pkg::MODE_RELOAD_UPDOWN;
      end else begin
         mode = updown_timer_pkg::MODE_RELOAD_UP;
      end
   end

   // Prescaler by 12 or 4; tick is one-cycle enable
   logic [3:0] pre_top;
   logic       pre_tick;
   logic       tick;
   assign pre_top = timer_mode_reg[updown_timer_pkg::MOD_FAST_PRE] ?
                    4'(updown_timer_pkg::PRESCALE_FAST - 1) :
                    4'(updown_timer_pkg::PRESCALE_SLOW - 1);
   assign pre_tick = (pre_reg >= pre_top);
   always_comb begin
      pre_next = pre_tick ? 4'h0 : pre_reg + 4'h1;
   end
   assign tick = run & (clk_src ? cnt_fall : pre_tick);

   logic wr_ctl;
   logic wr_stat;
   assign wr_ctl  = req.wr & (req.addr == updown_timer_pkg::ADDR_CONTROL);
   assign wr_stat = req.wr & (req.addr == updown_timer_pkg::ADDR_IRQ_STAT);

   // Counter, capture and flag next-state
   logic set_ovf;
   logic set_ext;
   logic tog_ext;
   logic ext_irq_ok;
   always_comb begin
      count_next    = count_reg;
      capture_next  = capture_reg;
      set_ovf       = 1'b0;
      set_ext       = 1'b0;
      tog_ext       = 1'b0;
      rate_ovf_next = 1'b0;
      ext_irq_ok    = 1'b1;
      case (mode)
         updown_timer_pkg::MODE_CAPTURE: begin
            if (tick) begin
               count_next = count_reg + 16'h0001;
               set_ovf = (count_reg == updown_timer_pkg::COUNT_MAX);
            end
            if (ext_en && trg_fall) begin
               capture_next = count_reg;
               set_ext = 1'b1;
               if (cap_clr) begin
                  count_next = updown_timer_pkg::COUNT_ZERO;
               end
            end
         end
         updown_timer_pkg::MODE_RELOAD_UP: begin
            if (ext_en && trg_fall) begin
               count_next = capture_reg;
               set_ext = 1'b1;
            end else if (tick) begin
               if (count_reg == updown_timer_pkg::COUNT_MAX) begin
                  count_next = capture_reg;
                  set_ovf = 1'b1;
               end else begin
                  count_next = count_reg + 16'h0001;
               end
            end
         end
         updown_timer_pkg::MODE_RELOAD_UPDOWN: begin
            ext_irq_ok = 1'b0;
            if (tick) begin
               if (trg_level) begin
                  if (count_reg == updown_timer_pkg::COUNT_MAX) begin
                     count_next = capture_reg;
                     set_ovf = 1'b1;
                     tog_ext = 1'b1;
                  end else begin
                     count_next = count_reg + 16'h0001;
                  end
               end else if (count_reg == capture_reg) begin
                  count_next = updown_timer_pkg::COUNT_MAX;
                  set_ovf = 1'b1;
                  tog_ext = 1'b1;
               end else begin
                  count_next = count_reg - 16'h0001;
               end
            end
         end
         updown_timer_pkg::MODE_RATE_GEN: begin
            if (tick) begin
               if (count_reg == updown_timer_pkg::COUNT_MAX) begin
                  count_next = capture_reg;
                  rate_ovf_next = 1'b1;
               end else begin
                  count_next = count_reg + 16'h0001;
               end
            end
            set_ext = ext_en & trg_fall;
         end
         default: begin
            count_next = count_reg;
         end
      endcase
      // Software writes to count or capture bytes when no tick, even on a trigger edge
      if (req.wr && !tick) begin
         case (req.addr)
            updown_timer_pkg::ADDR_CNT_LO: count_next[7:0]    = req.wdata;
            updown_timer_pkg::ADDR_CNT_HI: count_next[15:8]   = req.wdata;
            updown_timer_pkg::ADDR_CAP_LO: capture_next[7:0]  = req.wdata;
            updown_timer_pkg::ADDR_CAP_HI: capture_next[15:8] = req.wdata;
            default: ;
         endcase
      end
   end

   // Control, mode, status, mask next-state; hardware set beats clear
   logic ovf_now;
   logic ext_now;
   always_comb begin
      timer_control_next = timer_control_reg;
      timer_mode_next    = timer_mode_reg;
      irq_mask_next      = irq_mask_reg;
      irq_stat_next      = irq_stat_reg;
      if (wr_ctl) begin
         timer_control_next = req.wdata;
      end
      if (req.wr && req.addr == updown_timer_pkg::ADDR_MODE) begin
         timer_mode_next = req.wdata;
      end
      if (req.wr && req.addr == updown_timer_pkg::ADDR_IRQ_MASK) begin
         irq_mask_next = req.wdata[1:0];
      end
      if (wr_stat) begin
         irq_stat_next = irq_stat_reg & ~req.wdata[1:0];
      end
      ovf_now = timer_control_reg[updown_timer_pkg::CTL_OVF_FLAG];
      ext_now = timer_control_reg[updown_timer_pkg::CTL_EXT_FLAG];
      // Flags persist until software clears them; EXF also toggles on up/down reloads
      if (set_ovf) begin
         timer_control_next[updown_timer_pkg::CTL_OVF_FLAG] = 1'b1;
         irq_stat_next[updown_timer_pkg::IRQ_OVF] = 1'b1;
      end
      if (set_ext) begin
         timer_control_next[updown_timer_pkg::CTL_EXT_FLAG] = 1'b1;
         if (ext_irq_ok) begin
            irq_stat_next[updown_timer_pkg::IRQ_EXT] = 1'b1;
         end
      end else if (tog_ext) begin
         timer_control_next[updown_timer_pkg::CTL_EXT_FLAG] = ~ext_now;
      end
      if (!set_ovf && !wr_ctl) begin
         timer_control_next[updown_timer_pkg::CTL_OVF_FLAG] = ovf_now;
      end
   end

   // Read mux, data valid the cycle after the strobe
   always_comb begin
      rdata_next = 8'h00;
      if (req.rd) begin
         case (req.addr)
            updown_timer_pkg::ADDR_CONTROL:  rdata_next = timer_control_reg;
            updown_timer_pkg::ADDR_MODE:     rdata_next = timer_mode_reg;
            updown_timer_pkg::ADDR_CNT_LO:   rdata_next = count_reg[7:0];
            updown_timer_pkg::ADDR_CNT_HI:   rdata_next = count_reg[15:8];
            updown_timer_pkg::ADDR_CAP_LO:   rdata_next = capture_reg[7:0];
            updown_timer_pkg::ADDR_CAP_HI:   rdata_next = capture_reg[15:8];
            updown_timer_pkg::ADDR_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
            updown_timer_pkg::ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
            default:                         rdata_next = 8'h00;
         endcase
      end
   end

   // State registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         timer_control_reg <= updown_timer_pkg::CONTROL_RST;
         timer_mode_reg    <= updown_timer_pkg::MODE_RST;
         count_reg         <= updown_timer_pkg::COUNT_ZERO;
         capture_reg       <= updown_timer_pkg::COUNT_ZERO;
         irq_stat_reg      <= 2'h0;
         irq_mask_reg      <= 2'h0;
         pre_reg           <= 4'h0;
         o_rdata           <= 8'h00;
         o_rate_overflow   <= 1'b0;
      end else begin
         timer_control_reg <= timer_control_next;
         timer_mode_reg    <= timer_mode_next;
         count_reg         <= count_next;
         capture_reg       <= capture_next;
         irq_stat_reg      <= irq_stat_next;
         irq_mask_reg      <= irq_mask_next;
         pre_reg           <= pre_next;
         o_rdata           <= rdata_next;
         o_rate_overflow   <= rate_ovf_next;
      end
   end

   // Level interrupt from unmasked sticky bits
   assign o_irq = |(irq_stat_reg & irq_mask_reg);

   // Assertions
   sequence at_top_tick_s;
      tick && count_reg == updown_timer_pkg::COUNT_MAX;
   endsequence

   AST_NO_COUNT_WHEN_STOPPED: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (!run && !req.wr && !(ext_en && trg_fall)) |=> $stable(count_reg))
      else $error("Counter moved while stopped");

   AST_CAPTURE_OVF: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_CAPTURE) and at_top_tick_s
      |=> timer_control_reg[updown_timer_pkg::CTL_OVF_FLAG])
      else $error("Capture rollover lost overflow flag");

   AST_CAPTURE_COPY: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_CAPTURE && ext_en && trg_fall)
      |=> capture_reg == $past(count_reg))
      else $error("Capture did not copy count");

   AST_CAPTURE_CLEAR: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_CAPTURE && ext_en && trg_fall
       && cap_clr) |=> count_reg == 16'h0000)
      else $error("Counter not cleared after capture");

   AST_UP_RELOAD: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_RELOAD_UP && !(ext_en && trg_fall))
      and at_top_tick_s |=> count_reg == $past(capture_reg))
      else $error("Up rollover did not reload");

   AST_DOWN_TO_MAX: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_RELOAD_UPDOWN && tick && !trg_level
       && count_reg == capture_reg) |=> count_reg == 16'hffff)
      else $error("Down reload did not load max");

   AST_UPDOWN_NO_EXT_IRQ: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_RELOAD_UPDOWN && !wr_stat)
      |=> irq_stat_reg[updown_timer_pkg::IRQ_EXT]
          == $past(irq_stat_reg[updown_timer_pkg::IRQ_EXT]))
      else $error("External interrupt raised in up/down mode");

   AST_RATE_NO_OVF: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_RATE_GEN && !wr_ctl)
      |=> $stable(timer_control_reg[updown_timer_pkg::CTL_OVF_FLAG]))
      else $error("Rate mode set overflow flag");

   // Either reload in up/down mode, up at top or down at capture value
   sequence updown_reload_s;
      mode == updown_timer_pkg::MODE_RELOAD_UPDOWN && tick
      && (trg_level ? count_reg == updown_timer_pkg::COUNT_MAX
                    : count_reg == capture_reg);
   endsequence

   // A count byte write in the same cycle would win, so leave it out
   AST_TRIG_RELOAD: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_RELOAD_UP && ext_en && trg_fall
       && !req.wr) |=> count_reg == $past(capture_reg)
       && timer_control_reg[updown_timer_pkg::CTL_EXT_FLAG])
      else $error("Trigger edge did not reload");

   AST_UPDOWN_UP_RELOAD: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_RELOAD_UPDOWN && trg_level)
      and at_top_tick_s |=> count_reg == $past(capture_reg))
      else $error("Up/down overflow did not reload");

   AST_UPDOWN_TOGGLE: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      updown_reload_s |=>
      timer_control_reg[updown_timer_pkg::CTL_OVF_FLAG] &&
      timer_control_reg[updown_timer_pkg::CTL_EXT_FLAG]
      != $past(timer_control_reg[updown_timer_pkg::CTL_EXT_FLAG]))
      else $error("Up/down reload lost flag update");

   AST_RATE_EXT_FLAG: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (mode == updown_timer_pkg::MODE_RATE_GEN && ext_en && trg_fall)
      |=> timer_control_reg[updown_timer_pkg::CTL_EXT_FLAG]
          && irq_stat_reg[updown_timer_pkg::IRQ_EXT])
      else $error("Rate trigger edge lost external flag");

endmodule

//--- pin_driver_model.sv
`timescale 1ns/100ps
module pin_driver_model (
   input  wire logic i_clk,
   output logic      o_count_pin,
   output logic      o_trigger_pin
);
   // Both pins idle high, as an undriven input with pull-up would
   initial begin
      o_count_pin   = 1'b1;
      o_trigger_pin = 1'b1;
   end
   // Each level held 4 clocks so the 2-flop sync never drops an edge
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge i_clk);
         o_count_pin <= 1'b0;
         repeat (4) @(posedge i_clk);
         o_count_pin <= 1'b1;
      end
      repeat (5) @(posedge i_clk);
   endtask
   // Level for direction; low then high makes one falling edge
   task automatic trig(input logic lvl);
      @(posedge i_clk);
      o_trigger_pin <= lvl;
      repeat (5) @(posedge i_clk);
   endtask
endmodule

//--- updown_capture_reload_timer_tb.sv
`timescale 1ns/100ps
module updown_capture_reload_timer_tb;
   logic       i_clk;
   logic       i_rst_b;
   logic [3:0] i_addr;
   logic [7:0] i_wdata;
   logic       i_wr;
   logic       i_rd;
   logic       cpin;
   logic       tpin;
   logic [7:0] o_rdata;
   logic       o_irq;
   logic       o_rate_overflow;
   logic [15:0] v;
   int         miscompares = 0;
   int         n_tests     = 0;
   int         rate_pulses = 0;
   // Control, mode and status bit values
   localparam logic [7:0] CAP = 8'h01 << updown_timer_pkg::CTL_CAP_RELOAD;
   localparam logic [7:0] PIN = 8'h01 << updown_timer_pkg::CTL_CLK_SRC;
   localparam logic [7:0] RUN = 8'h01 << updown_timer_pkg::CTL_RUN;
   localparam logic [7:0] EXT = 8'h01 << updown_timer_pkg::CTL_EXT_TRIG;
   localparam logic [7:0] TXR = 8'h01 << updown_timer_pkg::CTL_TX_RATE;
   localparam logic [7:0] RXR = 8'h01 << updown_timer_pkg::CTL_RX_RATE;
   localparam logic [7:0] EXF = 8'h01 << updown_timer_pkg::CTL_EXT_FLAG;
   localparam logic [7:0] OVF = 8'h01 << updown_timer_pkg::CTL_OVF_FLAG;
   localparam logic [7:0] UPD = 8'h01 << updown_timer_pkg::MOD_UPDOWN;
   localparam logic [7:0] FST = 8'h01 << updown_timer_pkg::MOD_FAST_PRE;
   localparam logic [7:0] CLR = 8'h01 << updown_timer_pkg::MOD_CAP_CLEAR;
   localparam logic [7:0] SOV = 8'h01 << updown_timer_pkg::IRQ_OVF;
   localparam logic [7:0] SEX = 8'h01 << updown_timer_pkg::IRQ_EXT;
   localparam logic [3:0] A_CTL = updown_timer_pkg::ADDR_CONTROL;
   localparam logic [3:0] A_ST  = updown_timer_pkg::ADDR_IRQ_STAT;
   localparam logic [3:0] A_CNT = updown_timer_pkg::ADDR_CNT_LO;
   localparam logic [3:0] A_CAP = updown_timer_pkg::ADDR_CAP_LO;

   always #20 i_clk = ~i_clk;

   updown_capture_reload_timer dut (
      .i_clk                   (i_clk),
      .i_rst_b                 (i_rst_b),
      .i_addr                  (i_addr),
      .i_wdata                 (i_wdata),
      .i_wr                    (i_wr),
      .i_rd                    (i_rd),
      .i_ext_count_pin         (cpin),
      .i_trigger_direction_pin (tpin),
      .o_rdata                 (o_rdata),
      .o_irq                   (o_irq),
      .o_rate_overflow         (o_rate_overflow)
   );
   pin_driver_model pins (
      .i_clk         (i_clk),
      .o_count_pin   (cpin),
      .o_trigger_pin (tpin)
   );

   // Serial-port pulse stands one cycle, so count it at every edge
   always @(posedge i_clk) begin
      if (o_rate_overflow === 1'b1) rate_pulses++;
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
      // Let the write settle before a caller looks at o_irq
      #1;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   task automatic rchk(logic [3:0] a, logic [7:0] e, string nm);
      logic [7:0] d;
      rd(a, d);
      chk(nm, {8'h00, e}, {8'h00, d});
   endtask
   // Low byte at a, high byte at a+1
   task automatic rd16(logic [3:0] a, output logic [15:0] w);
      rd(a, w[7:0]);
      rd(a + 4'h1, w[15:8]);
   endtask
   task automatic wr16(logic [3:0] a, logic [15:0] w);
      wr(a, w[7:0]);
      wr(a + 4'h1, w[15:8]);
   endtask
   task automatic cchk(logic [3:0] a, logic [15:0] e, string nm);
      rd16(a, v);
      chk(nm, e, v);
   endtask
   // Prescaled runs: tick phase is free, so allow a lo..hi window around 120 cycles over the divisor
   task automatic prun(logic [7:0] md, int lo, int hi, string nm);
      wr16(A_CNT, 16'h0000);
      wr(updown_timer_pkg::ADDR_MODE, md);
      wr(A_CTL, RUN);
      repeat (120) @(posedge i_clk);
      wr(A_CTL, 8'h00);
      rd16(A_CNT, v);
      chk(nm, 16'h0001, {15'h0000, (v >= lo && v <= hi) === 1'b1});
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      i_clk   = 1'b0;
      i_rst_b = 1'b0;
      i_addr  = 4'h0;
      i_wdata = 8'h00;
      i_wr    = 1'b0;
      i_rd    = 1'b0;
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rchk(A_CTL, updown_timer_pkg::CONTROL_RST, "control reset");
      rchk(updown_timer_pkg::ADDR_MODE, updown_timer_pkg::MODE_RST, "mode");
      rchk(4'h8, 8'h00, "unmapped");
      prun(8'h00, 9, 11, "div 12 count");
      rd16(A_CNT, v);
      repeat (40) @(posedge i_clk);
      cchk(A_CNT, v, "stopped count");
      prun(FST, 29, 32, "div 4 count");
      // Pin clock: edges ignored until run is set
      wr16(A_CNT, 16'h0000);
      wr(A_CTL, PIN);
      pins.pulses(3);
      cchk(A_CNT, 16'h0000, "gated count");
      wr(A_CTL, PIN | RUN);
      pins.pulses(5);
      cchk(A_CNT, 16'h0005, "pin count");
      // Capture mode: wrap, capture, then capture with clear
      wr(updown_timer_pkg::ADDR_IRQ_MASK, SOV | SEX);
      wr16(A_CNT, 16'hfffd);
      wr(A_CTL, CAP | PIN | RUN | EXT);
      pins.pulses(3);
      cchk(A_CNT, 16'h0000, "capture wrap");
      rchk(A_CTL, CAP | PIN | RUN | EXT | OVF, "ovf flag");
      rchk(A_ST, SOV, "ovf status");
      chk("irq", 16'h0001, {15'h0000, o_irq});
      pins.pulses(2);
      pins.trig(1'b0);
      pins.trig(1'b1);
      cchk(A_CAP, 16'h0002, "captured");
      rchk(A_CTL, CAP | PIN | RUN | EXT | OVF | EXF, "ext flag");
      wr(A_ST, SOV | SEX);
      chk("irq cleared", 16'h0000, {15'h0000, o_irq});
      wr(A_CTL, CAP | PIN | RUN | EXT);
      rchk(A_CTL, CAP | PIN | RUN | EXT, "flags cleared");
      wr(updown_timer_pkg::ADDR_MODE, CLR);
      pins.pulses(4);
      pins.trig(1'b0);
      pins.trig(1'b1);
      cchk(A_CAP, 16'h0006, "capture 2");
      cchk(A_CNT, 16'h0000, "cleared count");
      // Masked: status set but no request
      wr(updown_timer_pkg::ADDR_IRQ_MASK, 8'h00);
      rchk(A_ST, SEX, "ext status");
      chk("masked irq", 16'h0000, {15'h0000, o_irq});
      wr(updown_timer_pkg::ADDR_IRQ_MASK, SOV | SEX);
      // Reload-up mode
      wr(updown_timer_pkg::ADDR_MODE, 8'h00);
      wr(A_ST, SOV | SEX);
      wr(A_CTL, PIN | RUN | EXT);
      wr16(A_CAP, 16'h1234);
      wr16(A_CNT, 16'hfffe);
      pins.pulses(2);
      cchk(A_CNT, 16'h1234, "up reload");
      rchk(A_CTL, PIN | RUN | EXT | OVF, "reload ovf");
      pins.pulses(3);
      pins.trig(1'b0);
      pins.trig(1'b1);
      cchk(A_CNT, 16'h1234, "trig reload");
      rchk(A_CTL, PIN | RUN | EXT | OVF | EXF, "trig exf");
      // Up/down mode: down past capture value, then up past FFFF
      wr(A_CTL, PIN | RUN);
      wr(A_ST, SOV | SEX);
      wr(updown_timer_pkg::ADDR_MODE, UPD);
      wr16(A_CAP, 16'h0010);
      wr16(A_CNT, 16'h0011);
      pins.trig(1'b0);
      pins.pulses(1);
      cchk(A_CNT, 16'h0010, "down count");
      pins.pulses(1);
      cchk(A_CNT, 16'hffff, "down reload");
      rchk(A_CTL, PIN | RUN | OVF | EXF, "down flags");
      rchk(A_ST, SOV, "no ext status");
      pins.trig(1'b1);
      wr(A_CTL, PIN | RUN | EXF);
      pins.pulses(1);
      cchk(A_CNT, 16'h0010, "up reload");
      rchk(A_CTL, PIN | RUN | OVF, "exf toggled");
      // Rate mode through each select bit, over capture select
      wr(updown_timer_pkg::ADDR_MODE, 8'h00);
      for (int i = 0; i < 2; i++) begin
         wr(A_CTL, (i == 0 ? TXR : RXR) | CAP | PIN | RUN | EXT);
         wr(A_ST, SOV | SEX);
         wr16(A_CAP, 16'hfff0);
         wr16(A_CNT, 16'hfffe);
         rate_pulses = 0;
         pins.pulses(2);
         cchk(A_CNT, 16'hfff0, "rate reload");
         chk("rate pulses", 16'h0001, 16'(rate_pulses));
         rchk(A_ST, 8'h00, "rate no ovf");
         pins.trig(1'b0);
         pins.trig(1'b1);
         rchk(A_ST, SEX, "rate ext");
         chk("rate irq", 16'h0001, {15'h0000, o_irq});
      end
      tally_and_finish();
   end
endmodule
